// file: rtl/contact_stop_speed_select.sv
// Speed source selection and stop-on-contact switching with AXI4-Lite regs
//
// Summary of operation
// - Contact-stop can only happen while the enable parameter equals 1.
// - In contact-stop mode the low preset is clamped to at most 30 Hz.
// - Second-function plus low select enters contact-stop at the low preset.
// - Contact-stop uses the second stall level, normal one if it is 9999.
// - Contact-stop at 3 Hz or less uses the contact carrier unless 9999.
// - Fast-response current limit is on normally and off in contact-stop.
// - Low-speed excitation scaling (0-300%) applies only in contact-stop.
// - Panel, combined, jog, PID, remote or auto-accel operation blocks it.
// - A remote setting selection of 1 to 3 blocks contact-stop entirely.
// - A jog request selects the jog frequency above everything else.
// - Jog off with low and second-function on gives low preset and mode.
// - Low, speed 4, 5, 6 and 7 follow the combinations of the selects.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module contact_stop_speed_select
	import contact_stop_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	input  wire logic [ADDR_W-1:0] i_awaddr,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic [3:0]        i_wstrb,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	output logic      [1:0]        o_bresp,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	input  wire logic [ADDR_W-1:0] i_araddr,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	output logic      [DATA_W-1:0] o_rdata,
	output logic      [1:0]        o_rresp,
	input  wire logic              i_high_speed_select,
	input  wire logic              i_middle_speed_select,
	input  wire logic              i_low_speed_select,
	input  wire logic              i_second_function_select,
	input  wire logic              i_jog_request,
	input  wire logic [PAR_W-1:0]  i_analog_freq,
	input  wire logic [PAR_W-1:0]  i_out_freq,
	output logic      [PAR_W-1:0]  o_freq_cmd,
	output logic                   o_contact_mode,
	output logic      [PAR_W-1:0]  o_stall_level,
	output logic      [PAR_W-1:0]  o_carrier_setting,
	output logic      [PAR_W-1:0]  o_excite_scale,
	output logic                   o_excite_en,
	output logic                   o_fast_limit_en
);

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Second value stands in when the first holds the no-setting code
	function automatic logic [15:0] pick(input logic [15:0] val,
	                                     input logic [15:0] alt);
		pick = (val == NO_SETTING) ? alt : val;
	endfunction

	// Merge the two low byte lanes of a write into a 16-bit word
	function automatic logic [15:0] merge(input logic [15:0] old,
	                                      input logic [31:0] wd,
	                                      input logic [3:0]  be);
		merge = old;
		if (be[0]) begin
			merge[7:0] = wd[7:0];
		end
		if (be[1]) begin
			merge[15:8] = wd[15:8];
		end
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [15:0]       enable_r;
	logic [15:0]       remote_r;
	logic [15:0]       opcfg_r;
	logic [15:0]       nstall_r;
	logic [15:0]       sstall_r;
	logic [15:0]       excite_r;
	logic [15:0]       ccarr_r;
	logic [15:0]       ncarr_r;
	logic              aw_have_r;
	logic [7:0]        aw_addr_r;
	logic              w_have_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              wr_fire;
	logic              wr_hit;
	logic              preset_we;
	rd_state_t         rd_state_r;
	logic [7:0]        ar_addr_r;
	logic [15:0]       mem_bus_data;
	logic [15:0]       mem_sel_data;
	logic              blocked;
	logic              contact_nxt;
	logic              analog_nxt;
	logic [2:0]        slot_nxt;
	logic              contact_r;
	logic              analog_r;
	logic              low_slot_r;
	logic [15:0]       rd_word;
	logic              rd_hit;

	// ****************************************************************
	// Write channel
	// ****************************************************************
	assign o_awready = !aw_have_r && !o_bvalid;
	assign o_wready  = !w_have_r && !o_bvalid;
	assign wr_fire   = aw_have_r && w_have_r && !o_bvalid;
	assign preset_we = wr_fire && ((aw_addr_r & PRESET_MASK) == OFS_PRESET);

	// Address and data are held until both have arrived
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_have_r  <= 1'b0;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= i_awaddr;
			end else if (wr_fire) begin
				aw_have_r <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= i_wdata;
				w_strb_r <= i_wstrb;
			end else if (wr_fire) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// Address decode for writes
	always_comb begin
		wr_hit = preset_we;
		unique case (aw_addr_r)
			OFS_ENABLE, OFS_REMOTE, OFS_OPCFG, OFS_NSTALL,
			OFS_SSTALL, OFS_EXCITE, OFS_CCARR, OFS_NCARR: wr_hit = 1'b1;
			default: ;
		endcase
	end

	// Write response, error for unmapped or read-only words
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_bvalid <= 1'b0;
			o_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			o_bvalid <= 1'b1;
			o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// Parameter registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			enable_r <= RST_ENABLE;
			remote_r <= RST_REMOTE;
			opcfg_r  <= RST_OPCFG;
			nstall_r <= RST_NSTALL;
			sstall_r <= RST_SSTALL;
			excite_r <= RST_EXCITE;
			ccarr_r  <= RST_CCARR;
			ncarr_r  <= RST_NCARR;
		end else if (wr_fire) begin
			unique case (aw_addr_r)
				OFS_ENABLE: enable_r <= merge(enable_r, w_data_r, w_strb_r);
				OFS_REMOTE: remote_r <= merge(remote_r, w_data_r, w_strb_r);
				OFS_OPCFG:  opcfg_r  <= merge(opcfg_r, w_data_r, w_strb_r);
				OFS_NSTALL: nstall_r <= merge(nstall_r, w_data_r, w_strb_r);
				OFS_SSTALL: sstall_r <= merge(sstall_r, w_data_r, w_strb_r);
				OFS_EXCITE: excite_r <= merge(excite_r, w_data_r, w_strb_r);
				OFS_CCARR:  ccarr_r  <= merge(ccarr_r, w_data_r, w_strb_r);
				OFS_NCARR:  ncarr_r  <= merge(ncarr_r, w_data_r, w_strb_r);
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************
	assign o_arready = (rd_state_r == RD_IDLE);
	assign o_rvalid  = (rd_state_r == RD_RESP);

	// Fetch cycle lets the preset store deliver its registered word
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rd_state_r <= RD_IDLE;
			ar_addr_r  <= 8'h00;
		end else begin
			unique case (rd_state_r)
				RD_IDLE: begin
					if (i_arvalid) begin
						rd_state_r <= RD_FETCH;
						ar_addr_r  <= i_araddr;
					end
				end
				RD_FETCH: rd_state_r <= RD_RESP;
				RD_RESP: begin
					if (i_rready) begin
						rd_state_r <= RD_IDLE;
					end
				end
				default: rd_state_r <= RD_IDLE;
			endcase
		end
	end

	// Read decode; status shows the live selection state
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 16'h0000;
		if ((ar_addr_r & PRESET_MASK) == OFS_PRESET) begin
			rd_word = mem_bus_data;
		end else begin
			unique case (ar_addr_r)
				OFS_ENABLE: rd_word = enable_r;
				OFS_REMOTE: rd_word = remote_r;
				OFS_OPCFG:  rd_word = opcfg_r;
				OFS_NSTALL: rd_word = nstall_r;
				OFS_SSTALL: rd_word = sstall_r;
				OFS_EXCITE: rd_word = excite_r;
				OFS_CCARR:  rd_word = ccarr_r;
				OFS_NCARR:  rd_word = ncarr_r;
				OFS_STATUS: rd_word = {10'h000, o_fast_limit_en, o_excite_en,
				                       analog_r, blocked, contact_r, i_jog_request};
				default:    rd_hit  = 1'b0;
			endcase
		end
	end

	// Read data registered in the fetch cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 32'h0000_0000;
			o_rresp <= RESP_OKAY;
		end else if (rd_state_r == RD_FETCH) begin
			o_rdata <= {16'h0000, rd_word};
			o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// ****************************************************************
	// Speed source selection
	// ****************************************************************
	always_comb begin
		blocked = (opcfg_r[OPM_LSB +: 2] != OPM_EXTERNAL) ||
		          opcfg_r[PID_BIT] ||
		          (opcfg_r[AUTO_LSB +: 8] != 8'h00) ||
		          ((remote_r >= REMOTE_MIN) && (remote_r <= REMOTE_MAX));
		contact_nxt = (enable_r == ENABLE_ON) && i_second_function_select &&
		              i_low_speed_select && !i_jog_request && !blocked;
		analog_nxt  = 1'b0;
		slot_nxt    = SLOT_LOW;
		if (i_jog_request) begin
			slot_nxt = SLOT_JOG;
		end else if (contact_nxt) begin
			slot_nxt = SLOT_LOW;
		end else begin
			unique case ({i_high_speed_select, i_middle_speed_select,
			              i_low_speed_select})
				3'b100: slot_nxt = SLOT_HIGH;
				3'b010: slot_nxt = SLOT_MIDDLE;
				3'b001: slot_nxt = SLOT_LOW;
				3'b011: slot_nxt = SLOT_SPEED4;
				3'b101: slot_nxt = SLOT_SPEED5;
				3'b110: slot_nxt = SLOT_SPEED6;
				3'b111: slot_nxt = SLOT_SPEED7;
				3'b000: analog_nxt = 1'b1;
			endcase
		end
	end

	preset_table preset_table_inst (
		.i_clk      (i_clk),
		.i_nrst     (i_nrst),
		.i_we       (preset_we),
		.i_waddr    (aw_addr_r[4:2]),
		.i_wdata    (w_data_r[15:0]),
		.i_wbe      (w_strb_r[1:0]),
		.i_sel_addr (slot_nxt),
		.o_sel_data (mem_sel_data),
		.i_bus_addr (i_araddr[4:2]),
		.o_bus_data (mem_bus_data)
	);

	// mode and derived settings refreshed each clock
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			contact_r         <= 1'b0;
			analog_r          <= 1'b0;
			low_slot_r        <= 1'b0;
			o_stall_level     <= RST_NSTALL;
			o_carrier_setting <= RST_NCARR;
			o_excite_scale    <= 16'h0000;
			o_excite_en       <= 1'b0;
			o_fast_limit_en   <= 1'b1;
		end else begin
			contact_r  <= contact_nxt;
			analog_r   <= analog_nxt;
			low_slot_r <= (slot_nxt == SLOT_LOW);
			o_stall_level <= contact_nxt ? pick(sstall_r, nstall_r) : nstall_r;
			if (contact_nxt && (i_out_freq <= CARRIER_FMAX)) begin
				o_carrier_setting <= pick(ccarr_r, ncarr_r);
			end else begin
				o_carrier_setting <= ncarr_r;
			end
			o_excite_en    <= contact_nxt && (excite_r <= EXCITE_MAX);
			o_excite_scale <= (contact_nxt && (excite_r <= EXCITE_MAX)) ?
			                  excite_r : 16'h0000;
			o_fast_limit_en <= !contact_nxt;
		end
	end

	assign o_contact_mode = contact_r;

	// Frequency command, one stage behind the preset store
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_freq_cmd <= 16'h0000;
		end else if (analog_r) begin
			o_freq_cmd <= i_analog_freq;
		end else if (contact_r && low_slot_r &&
		             (mem_sel_data > CONTACT_FMAX)) begin
			o_freq_cmd <= CONTACT_FMAX;
		end else begin
			o_freq_cmd <= mem_sel_data;
		end
	end

endmodule
`default_nettype wire

// file: rtl/contact_stop_pkg.sv
// Constants, register map and resets for the contact-stop speed selector
package contact_stop_pkg;

	// ****************************************************************
	// Bus and register map (byte addresses)
	// ****************************************************************
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          PAR_W         = 16;
	localparam logic [7:0]  OFS_ENABLE    = 8'h00;
	localparam logic [7:0]  OFS_REMOTE    = 8'h04;
	localparam logic [7:0]  OFS_OPCFG     = 8'h08;
	localparam logic [7:0]  OFS_NSTALL    = 8'h0c;
	localparam logic [7:0]  OFS_SSTALL    = 8'h10;
	localparam logic [7:0]  OFS_EXCITE    = 8'h14;
	localparam logic [7:0]  OFS_CCARR     = 8'h18;
	localparam logic [7:0]  OFS_NCARR     = 8'h1c;
	localparam logic [7:0]  OFS_STATUS    = 8'h20;
	localparam logic [7:0]  OFS_PRESET    = 8'h40;
	localparam logic [7:0]  PRESET_MASK   = 8'he0;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ****************************************************************
	// Field positions of the operation configuration word
	// ****************************************************************
	localparam int          OPM_LSB       = 0;
	localparam int          PID_BIT       = 2;
	localparam int          AUTO_LSB      = 8;
	localparam logic [1:0]  OPM_EXTERNAL  = 2'h0;

	// ****************************************************************
	// Parameter values and limits (frequencies in 0.01 Hz)
	// ****************************************************************
	localparam logic [15:0] ENABLE_ON     = 16'h0001;
	localparam logic [15:0] NO_SETTING    = 16'h270f;
	localparam logic [15:0] REMOTE_MIN    = 16'h0001;
	localparam logic [15:0] REMOTE_MAX    = 16'h0003;
	localparam logic [15:0] CONTACT_FMAX  = 16'h0bb8;
	localparam logic [15:0] CARRIER_FMAX  = 16'h012c;
	localparam logic [15:0] EXCITE_MAX    = 16'h012c;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0] RST_ENABLE    = 16'h0000;
	localparam logic [15:0] RST_REMOTE    = 16'h0000;
	localparam logic [15:0] RST_OPCFG     = 16'h0000;
	localparam logic [15:0] RST_NSTALL    = 16'h0096;
	localparam logic [15:0] RST_SSTALL    = 16'h270f;
	localparam logic [15:0] RST_EXCITE    = 16'h270f;
	localparam logic [15:0] RST_CCARR     = 16'h270f;
	localparam logic [15:0] RST_NCARR     = 16'h0001;
	localparam logic [15:0] RST_LOW       = 16'h03e8;
	localparam logic [15:0] RST_OTHER     = 16'h0000;

	// ****************************************************************
	// Preset table slots
	// ****************************************************************
	localparam logic [2:0]  SLOT_HIGH     = 3'h0;
	localparam logic [2:0]  SLOT_MIDDLE   = 3'h1;
	localparam logic [2:0]  SLOT_LOW      = 3'h2;
	localparam logic [2:0]  SLOT_SPEED4   = 3'h3;
	localparam logic [2:0]  SLOT_SPEED5   = 3'h4;
	localparam logic [2:0]  SLOT_SPEED6   = 3'h5;
	localparam logic [2:0]  SLOT_SPEED7   = 3'h6;
	localparam logic [2:0]  SLOT_JOG      = 3'h7;
	localparam int          SLOTS         = 8;

	// Bus read sequencer, one bit changes per step except RESP back to IDLE
	typedef enum logic [1:0] {
		RD_IDLE  = 2'b00,
		RD_FETCH = 2'b01,
		RD_RESP  = 2'b11
	} rd_state_t;

endpackage

// file: rtl/preset_table.sv
// Eight-word preset frequency store with two registered read ports
`timescale 1ns/10ps
`default_nettype none
module preset_table
	import contact_stop_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_we,
	input  wire logic [2:0]  i_waddr,
	input  wire logic [15:0] i_wdata,
	input  wire logic [1:0]  i_wbe,
	input  wire logic [2:0]  i_sel_addr,
	output logic      [15:0] o_sel_data,
	input  wire logic [2:0]  i_bus_addr,
	output logic      [15:0] o_bus_data
);

	logic [15:0] mem_r [SLOTS];

	// ****************************************************************
	// Storage with byte-lane writes
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int i = 0; i < SLOTS; i++) begin
				mem_r[i] <= (i == int'(SLOT_LOW)) ? RST_LOW : RST_OTHER;
			end
		end else if (i_we) begin
			if (i_wbe[0]) begin
				mem_r[i_waddr][7:0] <= i_wdata[7:0];
			end
			if (i_wbe[1]) begin
				mem_r[i_waddr][15:8] <= i_wdata[15:8];
			end
		end
	end

	// Registered read ports
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_sel_data <= RST_OTHER;
			o_bus_data <= RST_OTHER;
		end else begin
			o_sel_data <= mem_r[i_sel_addr];
			o_bus_data <= mem_r[i_bus_addr];
		end
	end

endmodule
`default_nettype wire

// file: tb/contact_stop_props.sv
// Port-level assertions for the contact-stop speed selector
`timescale 1ns/10ps
`default_nettype none
module contact_stop_props
	import contact_stop_pkg::*;
(
	input wire logic             i_clk,
	input wire logic             i_nrst,
	input wire logic             i_high_speed_select,
	input wire logic             i_middle_speed_select,
	input wire logic             i_low_speed_select,
	input wire logic             i_second_function_select,
	input wire logic             i_jog_request,
	input wire logic [PAR_W-1:0] i_analog_freq,
	input wire logic [PAR_W-1:0] o_freq_cmd,
	input wire logic             o_contact_mode,
	input wire logic [PAR_W-1:0] o_excite_scale,
	input wire logic             o_excite_en,
	input wire logic             o_fast_limit_en
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	// ****************************************************************
	// Sequences and properties
	// ****************************************************************
	sequence s_no_select;
		!i_jog_request && !i_high_speed_select &&
			!i_middle_speed_select && !i_low_speed_select;
	endsequence
	sequence s_held_mode;
		o_contact_mode ##1 o_contact_mode;
	endsequence
	property p_fast_limit;
		o_fast_limit_en != o_contact_mode;
	endproperty
	property p_jog;
		i_jog_request |=> !o_contact_mode;
	endproperty
	property p_need_both;
		!(i_low_speed_select && i_second_function_select) |=> !o_contact_mode;
	endproperty
	property p_entry;
		$rose(o_contact_mode) |-> $past(i_low_speed_select &&
			i_second_function_select && !i_jog_request);
	endproperty
	property p_excite_mode;
		o_excite_en |-> o_contact_mode && o_excite_scale <= EXCITE_MAX;
	endproperty
	property p_excite_off;
		!o_excite_en |-> o_excite_scale == 16'h0000;
	endproperty
	property p_clamp;
		s_held_mode |-> o_freq_cmd <= CONTACT_FMAX;
	endproperty
	property p_analog;
		s_no_select ##1 1'b1 |=> o_freq_cmd == $past(i_analog_freq);
	endproperty

	a_fast_limit: assert property (p_fast_limit)
		else $error("fast limit does not oppose contact mode");
	a_jog: assert property (p_jog)
		else $error("contact mode during jog");
	a_need_both: assert property (p_need_both)
		else $error("contact mode without both selects");
	a_entry: assert property (p_entry)
		else $error("contact mode entered without its cause");
	a_excite_mode: assert property (p_excite_mode)
		else $error("excitation scaling outside contact mode");
	a_excite_off: assert property (p_excite_off)
		else $error("excitation scale not zero while off");
	a_clamp: assert property (p_clamp)
		else $error("contact frequency above limit");
	a_analog: assert property (p_analog)
		else $error("analog command not passed through");
endmodule
`default_nettype wire

// file: tb/terminal_source.sv
// External contact source driving the five selector terminals
`timescale 1ns/10ps
`default_nettype none
module terminal_source (
	input  wire logic       i_clk,
	input  wire logic [4:0] i_cmd,
	output logic            o_high,
	output logic            o_middle,
	output logic            o_low,
	output logic            o_second,
	output logic            o_jog
);
	always_ff @(posedge i_clk) begin
		{o_jog, o_second, o_low, o_middle, o_high} <= i_cmd;
	end
endmodule
`default_nettype wire

// file: tb/contact_stop_speed_select_bench.sv
// Self-checking bench for the contact-stop speed selector
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	fail_count++; $display("Error %s exp %h got %h", nm, e, g); end end
module contact_stop_speed_select_bench import contact_stop_pkg::*;;
	logic        i_clk, i_nrst, i_awvalid, i_wvalid, i_bready, chk;
	logic        i_arvalid, i_rready, o_awready, o_wready, o_bvalid;
	logic        o_arready, o_rvalid, o_contact_mode, o_excite_en;
	logic        o_fast_limit_en, i_high_speed_select, i_jog_request;
	logic        i_middle_speed_select, i_low_speed_select;
	logic        i_second_function_select;
	logic [7:0]  i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0]  i_wstrb;
	logic [1:0]  o_bresp, o_rresp;
	logic [15:0] i_analog_freq, i_out_freq, o_freq_cmd, o_stall_level;
	logic [15:0] o_carrier_setting, o_excite_scale, cfg[8], pre[8];
	logic [4:0]  cmd;
	logic [66:0] exp_q[$];
	int          fail_count, n_compared;
	int          slot[8] = '{0, 0, 1, 5, 2, 4, 3, 6};
	logic [15:0] tbl[4][8] = '{
		'{0, 0, 0, 16'h270f, 16'h270f, 16'h270f, 16'h0dac, 16'h012c},
		'{1, 0, 0, 16'h270f, 16'h270f, 16'h270f, 16'h0dac, 16'h012c},
		'{1, 0, 0, 16'h00b4, 16'h012c, 16'h0005, 16'h00fa, 16'h012c},
		'{1, 4, 0, 16'h00b4, 16'h012d, 16'h0005, 16'h0bb8, 16'h012d}};
	logic [15:0] blk[7][2] = '{'{2, 1}, '{2, 2}, '{2, 4}, '{2, 16'h0100},
		'{1, 1}, '{1, 3}, '{0, 2}};

	contact_stop_speed_select contact_stop_speed_select_inst (
		.i_clk, .i_nrst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
		.o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
		.i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata,
		.o_rresp, .i_high_speed_select, .i_middle_speed_select,
		.i_low_speed_select, .i_second_function_select, .i_jog_request,
		.i_analog_freq, .i_out_freq, .o_freq_cmd, .o_contact_mode,
		.o_stall_level, .o_carrier_setting, .o_excite_scale, .o_excite_en,
		.o_fast_limit_en);
	terminal_source terminal_source_inst (.i_clk(i_clk), .i_cmd(cmd),
		.o_high(i_high_speed_select), .o_middle(i_middle_speed_select),
		.o_low(i_low_speed_select), .o_second(i_second_function_select),
		.o_jog(i_jog_request));

	// ****************************************************************
	// Expected outputs, bus tasks and checking
	// ****************************************************************
	function automatic logic [66:0] model(input logic [4:0] c);
		logic        md, xe;
		logic [15:0] f, st, ca;
		md = cfg[0] == 16'h0001 && !c[4] && cfg[2][2:0] == 3'h0 &&
			cfg[2][15:8] == 8'h00 && !(cfg[1] >= 1 && cfg[1] <= 3) &&
			c[2] && c[3];
		f = c[2:0] == 3'h0 ? i_analog_freq : pre[slot[c[2:0]]];
		if (md) f = pre[2] > CONTACT_FMAX ? CONTACT_FMAX : pre[2];
		if (c[4]) f = pre[7];
		st = md && cfg[4] != NO_SETTING ? cfg[4] : cfg[3];
		ca = md && i_out_freq <= CARRIER_FMAX && cfg[6] != NO_SETTING ?
			cfg[6] : cfg[7];
		xe = md && cfg[5] <= EXCITE_MAX;
		return {md, !md, xe, f, st, ca, xe ? cfg[5] : 16'h0000};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] r);
		logic ta, tw, ad, wd;
		i_awaddr <= a;
		i_wdata <= {16'h0000, d};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		exp_q.push_back({65'h0, r});
		ad = 1'b0;
		wd = 1'b0;
		while (!ad || !wd) begin
			@(negedge i_clk);
			ta = i_awvalid && o_awready;
			tw = i_wvalid && o_wready;
			@(posedge i_clk);
			if (ta) i_awvalid <= 1'b0;
			if (tw) i_wvalid <= 1'b0;
			ad = ad || ta;
			wd = wd || tw;
		end
		do @(negedge i_clk); while (!o_bvalid);
		@(posedge i_clk);
		i_bready <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		exp_q.push_back({33'h0, e});
		do @(negedge i_clk); while (!o_arready);
		@(posedge i_clk);
		i_arvalid <= 1'b0;
		do @(negedge i_clk); while (!o_rvalid);
		@(posedge i_clk);
		i_rready <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic setc(input int k, input logic [15:0] d);
		cfg[k] = d;
		wr(8'(k * 4), d, RESP_OKAY);
	endtask

	task automatic term(input logic [4:0] c);
		cmd <= c;
		repeat (4) @(posedge i_clk);
		exp_q.push_back(model(c));
		chk <= 1'b1;
		@(posedge i_clk);
		chk <= 1'b0;
	endtask

	task automatic report_and_stop();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Oldest note against each result
	always @(negedge i_clk) begin : watch
		logic [66:0] e;
		if ((o_bvalid && i_bready) || (o_rvalid && i_rready) || chk) begin
			e = exp_q.pop_front();
			if (chk) `CHK("outputs", e, {o_contact_mode, o_fast_limit_en,
				o_excite_en, o_freq_cmd, o_stall_level, o_carrier_setting,
				o_excite_scale})
			else if (o_bvalid) `CHK("bresp", e, {65'h0, o_bresp})
			else `CHK("rdata", e, {33'h0, o_rresp, o_rdata})
		end
	end

	// ****************************************************************
	// Clock, watchdog and test sequence
	// ****************************************************************
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	initial begin
		#1000000;
		fail_count++;
		report_and_stop();
	end

	initial begin
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, chk} = '0;
		{i_awaddr, i_araddr, i_wdata, i_analog_freq, i_out_freq} = '0;
		i_wstrb = 4'hf;
		cmd = 5'h00;
		i_nrst = 1'b0;
		void'($urandom(32'h7dc1));
		cfg = '{RST_ENABLE, RST_REMOTE, RST_OPCFG, RST_NSTALL, RST_SSTALL,
			RST_EXCITE, RST_CCARR, RST_NCARR};
		pre = '{RST_OTHER, RST_OTHER, RST_LOW, RST_OTHER, RST_OTHER,
			RST_OTHER, RST_OTHER, RST_OTHER};
		repeat (8) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		// Reset values, unmapped and read-only places
		for (int i = 0; i < 8; i++) rd(8'(i * 4), {18'h0, cfg[i]});
		for (int i = 0; i < 8; i++) rd(8'(64 + i * 4), {18'h0, pre[i]});
		rd(OFS_STATUS, {18'h0, 16'h0028});
		rd(8'h30, {RESP_SLVERR, 32'h0});
		wr(OFS_STATUS, 16'h0001, RESP_SLVERR);
		wr(8'h30, 16'h0001, RESP_SLVERR);
		for (int i = 0; i < 8; i++) begin
			pre[i] = 16'($urandom_range(40000));
			wr(8'(64 + i * 4), pre[i], RESP_OKAY);
		end
		// Low byte lane only, upper byte keeps its reset value
		i_wstrb <= 4'h1;
		wr(OFS_NSTALL, 16'h1234, RESP_OKAY);
		i_wstrb <= 4'hf;
		rd(OFS_NSTALL, {18'h0, RST_NSTALL[15:8], 8'h34});
		for (int r = 0; r < 11; r++) begin
			for (int k = 0; k < 6; k++) setc(k, tbl[r < 4 ? r : 2][k]);
			setc(6, r == 1 ? NO_SETTING : 16'(r % 10));
			setc(7, 16'(9 - r % 10));
			pre[2] = tbl[r < 4 ? r : 2][6];
			wr(OFS_PRESET + 8'h08, pre[2], RESP_OKAY);
			i_out_freq <= tbl[r < 4 ? r : 2][7];
			if (r >= 4) setc(int'(blk[r - 4][0]), blk[r - 4][1]);
			for (int c = 0; c < 32; c++) begin
				i_analog_freq <= 16'($urandom);
				term(5'(c));
			end
		end
		report_and_stop();
	end
endmodule
bind contact_stop_speed_select contact_stop_props contact_stop_props_inst (
	.i_clk, .i_nrst, .i_high_speed_select, .i_middle_speed_select,
	.i_low_speed_select, .i_second_function_select, .i_jog_request,
	.i_analog_freq, .o_freq_cmd, .o_contact_mode, .o_excite_scale,
	.o_excite_en, .o_fast_limit_en);
`default_nettype wire
